// ---- logic/fpg_pkg.sv ----
package fpg_pkg;

    // =========================================
    // geometry
    localparam int PORT_COUNT = 4;
    localparam int PORT_WIDTH = 8;
    localparam int ADDR_WIDTH = 8;
    localparam int SYNC_STAGES = 2;

    // =========================================
    // register offsets (printed offsets are indices; byte address is four times)
    localparam logic [5:0] IDX_A_PIN = 6'h00;
    localparam logic [5:0] IDX_A_DIR = 6'h01;
    localparam logic [5:0] IDX_A_LAT = 6'h02;
    localparam logic [5:0] IDX_B_PIN = 6'h03;
    localparam logic [5:0] IDX_B_DIR = 6'h04;
    localparam logic [5:0] IDX_B_LAT = 6'h05;
    localparam logic [5:0] IDX_C_PIN = 6'h06;
    localparam logic [5:0] IDX_C_DIR = 6'h07;
    localparam logic [5:0] IDX_C_LAT = 6'h08;
    localparam logic [5:0] IDX_D_PIN = 6'h09;
    localparam logic [5:0] IDX_D_DIR = 6'h0A;
    localparam logic [5:0] IDX_D_LAT = 6'h0B;
    localparam logic [5:0] IDX_CTRL = 6'h35;
    localparam logic [5:0] PORT_STRIDE = 6'h03;
    localparam logic [5:0] IDX_PORT_LAST = 6'h0B;

    // =========================================
    // chip control fields
    localparam int CTRL_PULLUP_OFF_BIT = 4;
    localparam logic [7:0] CTRL_WRITE_MASK = 8'h93;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    // =========================================
    // carriers
    typedef struct packed {
        logic [ADDR_WIDTH-1:0] adr;
        logic we;
        logic [3:0] sel;
        logic [31:0] dat;
    } fpg_wb_req_t;

    typedef struct packed {
        logic [PORT_COUNT*PORT_WIDTH-1:0] drive;
        logic [PORT_COUNT*PORT_WIDTH-1:0] oe_n;
        logic [PORT_COUNT*PORT_WIDTH-1:0] pull_on;
    } fpg_pad_out_t;

endpackage

// ---- logic/fpg_sync.sv ----
`timescale 1ns/1ps
module fpg_sync
#(
    parameter int WIDTH = 8
)
(
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    import fpg_pkg::*;

    logic [WIDTH-1:0] stage_one;

    // =========================================
    // two-flop synchroniser, first stage read only by second
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            stage_one <= '0;
            sync_out <= '0;
        end
        else
        begin
            stage_one <= async_in;
            sync_out <= stage_one;
        end
    end
endmodule

// ---- logic/fpg_pad_ctl.sv ----
`timescale 1ns/1ps
module fpg_pad_ctl
#(
    parameter int WIDTH = 8
)
(
    // port settings
    input wire logic [WIDTH-1:0] direction,
    input wire logic [WIDTH-1:0] latch,
    input wire logic [WIDTH-1:0] rx_force_input,
    input wire logic global_pullup_off,
    // pad controls
    output logic [WIDTH-1:0] drive,
    output logic [WIDTH-1:0] oe_n,
    output logic [WIDTH-1:0] pull_on
);
    import fpg_pkg::*;

    // =========================================
    // per-pin pad control
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_pin
            logic eff_dir;
            assign eff_dir = direction[i] & ~rx_force_input[i];
            assign drive[i] = latch[i];
            assign oe_n[i] = ~eff_dir;
            // forced input still follows the latch for pull-up
            assign pull_on[i] = ~eff_dir & latch[i] & ~global_pullup_off;
        end
    endgenerate
endmodule

// ---- logic/fpg_gpio.sv ----
// Functional notes
// - pull-up on when input and latch high
// - pull-up disable bit kills all pull-ups
// - chip control at 0x35, masked writable bits
// - port A latch, direction, pin levels
// - port B latch, direction, pin levels
// - port C latch, direction, pin levels
// - port D latch, direction, pin levels
// - forced receiver input keeps latch pull-up
`timescale 1ns/1ps
module fpg_gpio
#(
    parameter int PORTS = fpg_pkg::PORT_COUNT,
    parameter int WIDTH = fpg_pkg::PORT_WIDTH
)
(
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [fpg_pkg::ADDR_WIDTH-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // serial receiver overrides
    input wire logic [PORTS*WIDTH-1:0] rx_force_input,
    // pads
    input wire logic [PORTS*WIDTH-1:0] pad_in,
    output fpg_pkg::fpg_pad_out_t pad_out
);
    import fpg_pkg::*;

    // word position of each register inside a port's group of three
    localparam logic [1:0] FIELD_PIN = 2'(IDX_A_PIN - IDX_A_PIN);
    localparam logic [1:0] FIELD_DIR = 2'(IDX_A_DIR - IDX_A_PIN);
    localparam logic [1:0] FIELD_LAT = 2'(IDX_A_LAT - IDX_A_PIN);

    // =========================================
    // storage
    logic [WIDTH-1:0] latch [PORTS];
    logic [WIDTH-1:0] direction [PORTS];
    logic [7:0] chip_control_reg;
    logic [PORTS*WIDTH-1:0] pin_sync;
    logic global_pullup_off;

    fpg_wb_req_t req;
    logic access;
    logic [5:0] reg_idx;
    logic aligned;
    logic is_port;
    logic is_ctrl;
    logic [1:0] port_sel;
    logic [1:0] port_field;
    logic hit;
    logic [31:0] next_rdata;
    logic wr_ok;
    logic rd_ok;
    logic [WIDTH-1:0] pin_level [PORTS];
    logic ctrl_wr;
    logic [7:0] next_ctrl;

    assign req = '{adr: wb_adr_i, we: wb_we_i, sel: wb_sel_i, dat: wb_dat_i};
    assign access = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    assign reg_idx = req.adr[7:2];
    assign aligned = (req.adr[1:0] == 2'h0);
    assign global_pullup_off = chip_control_reg[CTRL_PULLUP_OFF_BIT];
    assign wr_ok = access && req.we && req.sel[0];
    assign rd_ok = access && !req.we;
    assign ctrl_wr = wr_ok && is_ctrl;

    // =========================================
    // address decode, one branch per mapped word
    always_comb
    begin
        is_port = 1'b0;
        is_ctrl = 1'b0;
        hit = 1'b0;
        port_sel = 2'h0;
        port_field = FIELD_PIN;
        if (aligned)
        begin
            case (reg_idx)
                IDX_A_PIN:
                begin
                    is_port = 1'b1;
                    hit = 1'b1;
                    port_sel = 2'h0;
                    port_field = FIELD_PIN;
                end
                IDX_A_DIR:
                begin
                    is_port = 1'b1;
                    hit = 1'b1;
                    port_sel = 2'h0;
                    port_field = FIELD_DIR;
                end
                IDX_A_LAT:
                begin
                    is_port = 1'b1;
                    hit = 1'b1;
                    port_sel = 2'h0;
                    port_field = FIELD_LAT;
                end
                IDX_B_PIN:
                begin
                    is_port = 1'b1;
                    hit = 1'b1;
                    port_sel = 2'h1;
                    port_field = FIELD_PIN;
                end
                IDX_B_DIR:
                begin
                    is_port = 1'b1;
                    hit = 1'b1;
                    port_sel = 2'h1;
                    port_field = FIELD_DIR;
                end
                IDX_B_LAT:
                begin
                    is_port = 1'b1;
                    hit = 1'b1;
                    port_sel = 2'h1;
                    port_field = FIELD_LAT;
                end
                IDX_C_PIN:
                begin
                    is_port = 1'b1;
                    hit = 1'b1;
                    port_sel = 2'h2;
                    port_field = FIELD_PIN;
                end
                IDX_C_DIR:
                begin
                    is_port = 1'b1;
                    hit = 1'b1;
                    port_sel = 2'h2;
                    port_field = FIELD_DIR;
                end
                IDX_C_LAT:
                begin
                    is_port = 1'b1;
                    hit = 1'b1;
                    port_sel = 2'h2;
                    port_field = FIELD_LAT;
                end
                IDX_D_PIN:
                begin
                    is_port = 1'b1;
                    hit = 1'b1;
                    port_sel = 2'h3;
                    port_field = FIELD_PIN;
                end
                IDX_D_DIR:
                begin
                    is_port = 1'b1;
                    hit = 1'b1;
                    port_sel = 2'h3;
                    port_field = FIELD_DIR;
                end
                IDX_D_LAT:
                begin
                    is_port = 1'b1;
                    hit = 1'b1;
                    port_sel = 2'h3;
                    port_field = FIELD_LAT;
                end
                IDX_CTRL:
                begin
                    is_ctrl = 1'b1;
                    hit = 1'b1;
                end
                default:
                begin
                    hit = 1'b0;
                end
            endcase
        end
    end

    // =========================================
    // pin synchroniser
    fpg_sync #(
        .WIDTH(PORTS*WIDTH)
    ) u_sync (
        .clock(clock),
        .arst_n(arst_n),
        .async_in(pad_in),
        .sync_out(pin_sync)
    );

    // =========================================
    // port registers and pad control
    genvar p;
    generate
        for (p = 0; p < PORTS; p++)
        begin : g_port
            logic wr_here;
            logic wr_lat;
            logic wr_dir;
            logic wr_pin;
            assign wr_here = wr_ok && is_port && (port_sel == 2'(p));
            assign wr_lat = wr_here && (port_field == FIELD_LAT);
            assign wr_dir = wr_here && (port_field == FIELD_DIR);
            assign wr_pin = wr_here && (port_field == FIELD_PIN);

            // output latch: plain write, or toggle through the level word
            always_ff @(posedge clock or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    latch[p] <= LATCH_RESET;
                end
                else if (wr_lat)
                begin
                    latch[p] <= req.dat[WIDTH-1:0];
                end
                else if (wr_pin)
                begin
                    // writing ones to the level register toggles the latch
                    latch[p] <= latch[p] ^ req.dat[WIDTH-1:0];
                end
            end

            // direction register
            always_ff @(posedge clock or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    direction[p] <= DIR_RESET;
                end
                else if (wr_dir)
                begin
                    direction[p] <= req.dat[WIDTH-1:0];
                end
            end

            // synchronised levels of this port
            assign pin_level[p] = pin_sync[p*WIDTH +: WIDTH];

            fpg_pad_ctl #(
                .WIDTH(WIDTH)
            ) u_pad (
                .direction(direction[p]),
                .latch(latch[p]),
                .rx_force_input(rx_force_input[p*WIDTH +: WIDTH]),
                .global_pullup_off(global_pullup_off),
                .drive(pad_out.drive[p*WIDTH +: WIDTH]),
                .oe_n(pad_out.oe_n[p*WIDTH +: WIDTH]),
                .pull_on(pad_out.pull_on[p*WIDTH +: WIDTH])
            );
        end
    endgenerate

    // =========================================
    // chip control register
    // read-only bits keep their value
    always_comb
    begin
        next_ctrl = (req.dat[7:0] & CTRL_WRITE_MASK)
            | (chip_control_reg & ~CTRL_WRITE_MASK);
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            chip_control_reg <= CTRL_RESET;
        end
        else if (ctrl_wr)
        begin
            chip_control_reg <= next_ctrl;
        end
    end

    // =========================================
    // read mux
    always_comb
    begin
        next_rdata = READ_ZERO;
        if (is_ctrl)
        begin
            next_rdata[7:0] = chip_control_reg;
        end
        else if (is_port)
        begin
            case (port_field)
                FIELD_PIN:
                begin
                    next_rdata[WIDTH-1:0] = pin_level[port_sel];
                end
                FIELD_DIR:
                begin
                    next_rdata[WIDTH-1:0] = direction[port_sel];
                end
                FIELD_LAT:
                begin
                    next_rdata[WIDTH-1:0] = latch[port_sel];
                end
                default:
                begin
                    next_rdata = READ_ZERO;
                end
            endcase
        end
    end

    // =========================================
    // bus answer, one wait state
    // ack for mapped words, one cycle after the request is taken
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wb_ack_o <= 1'b0;
        end
        else
        begin
            wb_ack_o <= access & hit;
        end
    end

    // err for unmapped or misaligned words, nothing is written
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wb_err_o <= 1'b0;
        end
        else
        begin
            wb_err_o <= access & ~hit;
        end
    end

    // read data holds until the next mapped read
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wb_dat_o <= READ_ZERO;
        end
        else if (rd_ok && hit)
        begin
            wb_dat_o <= next_rdata;
        end
    end
endmodule

// ---- tb/fpg_gpio_asserts.sv ----
`timescale 1ns/1ps
module fpg_gpio_asserts
(
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [fpg_pkg::ADDR_WIDTH-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    // pins
    input wire logic [31:0] rx_force_input,
    input wire fpg_pkg::fpg_pad_out_t pad_out
);
    import fpg_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    logic take;
    logic wr;
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign wr = take && wb_we_i && wb_sel_i[0];
    // ==========================
    // bus answers
    chk_single_answer: assert property (take |=> wb_ack_o ^ wb_err_o)
        else $error("request not answered by exactly one of ack and err");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_misaligned_err: assert property (take && wb_adr_i[1:0] != 2'h0 |=> wb_err_o)
        else $error("misaligned access not refused");
    chk_read_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("read data upper bits set");
    // ==========================
    // pad control
    chk_pullup_kill: assert property (wr && wb_adr_i == 8'hD4 && wb_dat_i[4]
        |=> pad_out.pull_on == 32'h0)
        else $error("pull-up left on after global disable");
    chk_pullup_input: assert property ((pad_out.pull_on & ~pad_out.oe_n) == 32'h0)
        else $error("pull-up on a driven pin");
    chk_pullup_latch: assert property ((pad_out.pull_on & ~pad_out.drive) == 32'h0)
        else $error("pull-up with latch low");
    chk_forced_input: assert property ((rx_force_input & ~pad_out.oe_n) == 32'h0)
        else $error("forced input pin driven");
    chk_dir_write: assert property (wr && wb_adr_i == 8'h04 |=> pad_out.oe_n[7:0]
        == ~($past(wb_dat_i[7:0]) & ~rx_force_input[7:0]))
        else $error("direction write not seen on enables");
    chk_latch_write: assert property (wr && wb_adr_i == 8'h20
        |=> pad_out.drive[23:16] == $past(wb_dat_i[7:0]))
        else $error("latch write not seen on drive");
    cover property (wr);
    cover property (wb_err_o);
    cover property (pad_out.pull_on != 32'h0);
endmodule
bind fpg_gpio fpg_gpio_asserts u_fpg_gpio_asserts (.clock, .arst_n, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o,
    .rx_force_input, .pad_out);

// ---- tb/fpg_pins.sv ----
`timescale 1ns/1ps
module fpg_pins
(
    // clock
    input wire logic clock,
    // pad side of the block
    input wire fpg_pkg::fpg_pad_out_t pad_out,
    // external drivers
    input wire logic [31:0] ext_en,
    input wire logic [31:0] ext_val,
    output logic [31:0] pad_in
);
    import fpg_pkg::*;
    logic [31:0] float_val = 32'h0;
    // lines nobody holds wander every cycle
    always @(posedge clock)
    begin
        float_val <= ~float_val;
    end
    assign pad_in = (~pad_out.oe_n & pad_out.drive)
        | (pad_out.oe_n & ext_en & ext_val)
        | (pad_out.oe_n & ~ext_en & (pad_out.pull_on | float_val));
endmodule

// ---- tb/fpg_gpio_test.sv ----
`timescale 1ns/1ps
module fpg_gpio_test;
    import fpg_pkg::*;
    logic clock;
    logic arst_n;
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [31:0] dat;
    logic [31:0] dat_o;
    logic ack;
    logic err;
    logic [31:0] rx_force;
    logic [31:0] ext_en;
    logic [31:0] ext_val;
    logic [31:0] pad_in;
    fpg_pad_out_t pad_out;
    int n_mismatch = 0;
    int n_compared = 0;
    logic [7:0] v;
    logic e;
    logic [7:0] lat;
    fpg_gpio u_fpg_gpio (.clock(clock), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .wb_err_o(err), .rx_force_input(rx_force), .pad_in(pad_in),
        .pad_out(pad_out));
    fpg_pins u_fpg_pins (.clock(clock), .pad_out(pad_out), .ext_en(ext_en),
        .ext_val(ext_val), .pad_in(pad_in));
    // ==========================
    // checking and bus tasks
    task automatic print_verdict();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want)
        begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
        output logic [7:0] r, output logic er);
        int n;
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {24'h0, d};
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (ack !== 1'b1 && err !== 1'b1 && n < 20);
        r = dat_o[7:0];
        er = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 20)
        begin
            n_mismatch++;
            print_verdict();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, a, d, v, e);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] want);
        xfer(1'b0, a, 8'h00, v, e);
        check({24'h0, v}, {24'h0, want});
    endtask
    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    // ==========================
    // main sequence
    initial
    begin
        arst_n = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        dat = 32'h0;
        rx_force = 32'h0;
        ext_en = 32'h0F0F_0F0F;
        ext_val = 32'h0505_0505;
        repeat (2) @(posedge clock);
        arst_n <= 1'b1;
        for (int p = 0; p < 4; p++)
        begin
            rdc(8'(12 * p + 4), 8'h00);
            rdc(8'(12 * p + 8), 8'h00);
        end
        rdc(8'hD4, 8'h00);
        check(pad_out.oe_n, 32'hFFFF_FFFF);
        for (int p = 0; p < 4; p++)
        begin
            wr(8'(12 * p + 4), 8'hF0);
            wr(8'(12 * p + 8), 8'h96 ^ 8'(p));
        end
        repeat (3) @(posedge clock);
        for (int p = 0; p < 4; p++)
        begin
            lat = 8'h96 ^ 8'(p);
            rdc(8'(12 * p + 4), 8'hF0);
            rdc(8'(12 * p + 8), lat);
            rdc(8'(12 * p), (lat & 8'hF0) | 8'h05);
            check(pad_out.pull_on[8 * p +: 8], lat & 8'h0F);
            check(pad_out.drive[8 * p +: 8], lat);
        end
        wr(8'hD4, 8'hFF);
        rdc(8'hD4, 8'h93);
        check(pad_out.pull_on, 32'h0);
        wr(8'hD4, 8'h00);
        check(pad_out.pull_on[7:0], 8'h06);
        rx_force <= 32'h0100_0000;
        wr(8'h28, 8'hF1);
        check(pad_out.oe_n[31:24], 8'h0F);
        check(pad_out.pull_on[31:24], 8'h05);
        // ones written to a level word flip the latch bits
        wr(8'h00, 8'h0F);
        rdc(8'h08, 8'h99);
        xfer(1'b1, 8'h30, 8'hFF, v, e);
        check(e, 1'b1);
        xfer(1'b0, 8'h05, 8'h00, v, e);
        check(e, 1'b1);
        print_verdict();
    end
endmodule
